/* File: rtl/ffc_pkg.sv */
`default_nettype none
package ffc_pkg;
    localparam int ATTEN_WORD_BITS = 8;
    localparam int ATTEN_COUNT     = 4;
    localparam int CONV_BITS       = 12;
    localparam int CONV_CHANNELS   = 8;
    localparam int CONV_FRAME_BITS = 24;
    localparam int CONV_CMD_BITS   = 4;
    localparam int CONV_ADDR_BITS  = 3;
    localparam logic [CONV_CMD_BITS-1:0] CONV_CMD_LOAD_UPDATE = 4'h3;
    localparam logic [CONV_BITS-1:0]     CONV_RESET_CODE      = 12'h000;
    localparam logic [CONV_BITS-1:0]     CONV_FULL_CODE       = 12'hfff;
    localparam int IDX_FAN   = 0;
    localparam int IDX_BACK  = 4;
    localparam int IDX_HOR   = 5;
    localparam int IDX_VERT  = 6;
    localparam int IDX_LONG  = 7;
    localparam int ATT_LONG  = 0;
    localparam int ATT_VERT  = 1;
    localparam int ATT_HOR   = 2;
    localparam int ATT_BACK  = 3;
    localparam int TACH_EDGES_PER_REV = 4;
    localparam int TACH_PERIODS_PER_REV = 2;
endpackage
`default_nettype wire

/* File: rtl/ffc_control_port.sv */
`timescale 1ns/1ps
`default_nettype none
module ffc_control_port #(
    parameter int TACH_HALF_CYCLES = 100000
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   atten_shift_clock,
    input  wire logic                   atten_shift_data,
    input  wire logic                   longitudinal_latch_strobe,
    input  wire logic                   vertical_latch_strobe,
    input  wire logic                   horizontal_latch_strobe,
    input  wire logic                   backend_latch_strobe,
    output logic                        longitudinal_shift_readback,
    output logic                        vertical_shift_readback,
    output logic                        horizontal_shift_readback,
    output logic                        backend_shift_readback,
    output logic [7:0]                  longitudinal_setting,
    output logic [7:0]                  vertical_setting,
    output logic [7:0]                  horizontal_setting,
    output logic [7:0]                  backend_setting,
    input  wire logic                   converter_select_n,
    input  wire logic                   converter_serial_clock,
    input  wire logic                   converter_serial_data,
    output logic [11:0]                 fan_speed_channel,
    output logic [11:0]                 fan_drive_level,
    output logic [11:0]                 backend_phase_channel,
    output logic [11:0]                 horizontal_phase_channel,
    output logic [11:0]                 vertical_phase_channel,
    output logic [11:0]                 longitudinal_phase_channel,
    input  wire logic                   thermometer_line_in,
    output logic                        thermometer_line_out,
    output logic                        thermometer_line_oe_n,
    output logic                        fan_speed_pulse_out,
    output logic                        fan_speed_pulse_oe_n
);
    localparam int AW = ffc_pkg::ATTEN_WORD_BITS;
    localparam int AN = ffc_pkg::ATTEN_COUNT;
    localparam int CB = ffc_pkg::CONV_BITS;
    localparam int FB = ffc_pkg::CONV_FRAME_BITS;

    // converter select idles high; resetting it low would fake a frame edge
    localparam logic [8:0] SYNC_IDLE = 9'h040;

    // two-flop synchronisers for every shift, strobe and converter pin input
    logic [8:0] sync1_reg;
    logic [8:0] sync2_reg;
    logic [8:0] sync_prev_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg     <= SYNC_IDLE;
            sync2_reg     <= SYNC_IDLE;
            sync_prev_reg <= SYNC_IDLE;
        end else begin
            sync1_reg <= {converter_serial_data, converter_serial_clock, converter_select_n,
                          backend_latch_strobe, horizontal_latch_strobe,
                          vertical_latch_strobe, longitudinal_latch_strobe,
                          atten_shift_data, atten_shift_clock};
            sync2_reg     <= sync1_reg;
            sync_prev_reg <= sync2_reg;
        end
    end

    logic            a_clk_rise;
    logic            a_data;
    logic [AN-1:0]   le_now;
    logic            c_sel_n;
    logic            c_clk_rise;
    logic            c_data;
    assign a_clk_rise = sync2_reg[0] & ~sync_prev_reg[0];
    assign a_data     = sync2_reg[1];
    assign le_now     = sync2_reg[5:2];
    assign c_sel_n    = sync2_reg[6];
    assign c_clk_rise = sync2_reg[7] & ~sync_prev_reg[7];
    assign c_data     = sync2_reg[8];

    // attenuator chain: every device gets the same bits, readback is each msb
    logic [AW-1:0] atten_shift_reg [AN];
    logic [AW-1:0] atten_latch_reg [AN];
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < AN; i++) begin
                atten_shift_reg[i] <= '0;
            end
        end else if (a_clk_rise) begin
            for (int i = 0; i < AN; i++) begin
                atten_shift_reg[i] <= {atten_shift_reg[i][AW-2:0], a_data};
            end
        end
    end

    // latch commits while strobe high, held when it drops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < AN; i++) begin
                atten_latch_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < AN; i++) begin
                if (le_now[i]) begin
                    atten_latch_reg[i] <= atten_shift_reg[i];
                end
            end
        end
    end

    assign longitudinal_shift_readback = atten_shift_reg[ffc_pkg::ATT_LONG][AW-1];
    assign vertical_shift_readback     = atten_shift_reg[ffc_pkg::ATT_VERT][AW-1];
    assign horizontal_shift_readback   = atten_shift_reg[ffc_pkg::ATT_HOR][AW-1];
    assign backend_shift_readback      = atten_shift_reg[ffc_pkg::ATT_BACK][AW-1];
    assign longitudinal_setting = atten_latch_reg[ffc_pkg::ATT_LONG];
    assign vertical_setting     = atten_latch_reg[ffc_pkg::ATT_VERT];
    assign horizontal_setting   = atten_latch_reg[ffc_pkg::ATT_HOR];
    assign backend_setting      = atten_latch_reg[ffc_pkg::ATT_BACK];

    // converter serial port: 24-bit frame, command/address/code, msb first
    logic [FB-1:0] conv_frame_reg;
    logic [4:0]    conv_count_reg;
    logic [CB-1:0] conv_code_reg [ffc_pkg::CONV_CHANNELS];
    logic          sel_prev_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conv_frame_reg <= '0;
            conv_count_reg <= 5'h00;
            sel_prev_reg   <= 1'b1;
        end else begin
            sel_prev_reg <= c_sel_n;
            if (c_sel_n) begin
                conv_count_reg <= 5'h00;
            end else if (c_clk_rise) begin
                conv_frame_reg <= {conv_frame_reg[FB-2:0], c_data};
                // saturate one past a full frame so long frames are refused too
                if (conv_count_reg != 5'(FB + 1)) begin
                    conv_count_reg <= conv_count_reg + 5'h01;
                end
            end
        end
    end

    // short or long frames are dropped so a glitch never loads a stray code
    logic          frame_done;
    logic          frame_load;
    logic [2:0]    frame_addr;
    logic [CB-1:0] frame_code;
    assign frame_done = c_sel_n & ~sel_prev_reg & (conv_count_reg == 5'(FB));
    assign frame_addr = conv_frame_reg[FB-ffc_pkg::CONV_CMD_BITS-1 -: ffc_pkg::CONV_ADDR_BITS];
    assign frame_code = conv_frame_reg[CB-1:0];
    assign frame_load = frame_done
                        && (conv_frame_reg[FB-1 -: ffc_pkg::CONV_CMD_BITS]
                            == ffc_pkg::CONV_CMD_LOAD_UPDATE);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ffc_pkg::CONV_CHANNELS; i++) begin
                conv_code_reg[i] <= ffc_pkg::CONV_RESET_CODE;
            end
        end else if (frame_load) begin
            conv_code_reg[frame_addr] <= frame_code;
        end
    end

    // drive level kept in its own flop so the output is not an adder
    logic [CB-1:0] fan_drive_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fan_drive_reg <= ffc_pkg::CONV_FULL_CODE - ffc_pkg::CONV_RESET_CODE;
        end else if (frame_load && frame_addr == 3'(ffc_pkg::IDX_FAN)) begin
            fan_drive_reg <= ffc_pkg::CONV_FULL_CODE - frame_code;
        end
    end

    assign fan_speed_channel          = conv_code_reg[ffc_pkg::IDX_FAN];
    assign backend_phase_channel      = conv_code_reg[ffc_pkg::IDX_BACK];
    assign horizontal_phase_channel   = conv_code_reg[ffc_pkg::IDX_HOR];
    assign vertical_phase_channel     = conv_code_reg[ffc_pkg::IDX_VERT];
    assign longitudinal_phase_channel = conv_code_reg[ffc_pkg::IDX_LONG];
    // inverted drive, full scale at code zero
    assign fan_drive_level = fan_drive_reg;

    // thermometer line only released here; the sensor itself sits outside
    assign thermometer_line_out  = 1'b0;
    assign thermometer_line_oe_n = 1'b1;

    // tachometer model: open collector pulls low for one half-period of each period
    logic [31:0] tach_count_reg;
    logic        tach_level_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tach_count_reg <= 32'h0000_0000;
            tach_level_reg <= 1'b1;
        end else if (tach_count_reg >= 32'(TACH_HALF_CYCLES - 1)) begin
            tach_count_reg <= 32'h0000_0000;
            tach_level_reg <= ~tach_level_reg;
        end else begin
            tach_count_reg <= tach_count_reg + 32'h0000_0001;
        end
    end
    assign fan_speed_pulse_out  = 1'b0;
    assign fan_speed_pulse_oe_n = tach_level_reg;

    chk_latch_copy: assert property (@(posedge clock) disable iff (!rst_n)
        le_now[0] |=> atten_latch_reg[0] == $past(atten_shift_reg[0]))
        else $error("latch did not copy shift word");
    chk_readback_msb: assert property (@(posedge clock) disable iff (!rst_n)
        a_clk_rise |=> longitudinal_shift_readback == $past(atten_shift_reg[0][AW-2]))
        else $error("readback not shifted msb");
    chk_shared_bits: assert property (@(posedge clock) disable iff (!rst_n)
        atten_shift_reg[0] == atten_shift_reg[3])
        else $error("attenuators disagree");
    chk_fan_invert: assert property (@(posedge clock) disable iff (!rst_n)
        fan_drive_level + fan_speed_channel == ffc_pkg::CONV_FULL_CODE)
        else $error("fan drive not inverted");
    chk_no_stray: assert property (@(posedge clock) disable iff (!rst_n)
        !frame_done |=> $stable(conv_code_reg[ffc_pkg::IDX_FAN]))
        else $error("code changed without frame");
    chk_tach_half: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(tach_level_reg) |-> tach_count_reg == 32'h0)
        else $error("tach toggled off schedule");
    chk_thermo_rel: assert property (@(posedge clock) disable iff (!rst_n)
        thermometer_line_oe_n)
        else $error("thermometer line driven");
    chk_frame_count: assert property (@(posedge clock) disable iff (!rst_n)
        c_sel_n |=> conv_count_reg == 5'h00)
        else $error("frame count not cleared");
    sequence fan_frame_seen;
        frame_load && frame_addr == 3'(ffc_pkg::IDX_FAN);
    endsequence
    chk_fan_load: assert property (@(posedge clock) disable iff (!rst_n)
        fan_frame_seen |=> fan_speed_channel == $past(frame_code))
        else $error("fan channel missed its frame");
endmodule // ffc_control_port
`default_nettype wire

/* File: verif/ffc_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ffc_ctrl_model (
    input  wire logic       clock,
    output logic            atten_shift_clock,
    output logic            atten_shift_data,
    output logic [3:0]      latch_strobe,
    output logic            converter_select_n,
    output logic            converter_serial_clock,
    output logic            converter_serial_data
);
    initial begin
        atten_shift_clock = 1'b0;
        atten_shift_data = 1'b0;
        latch_strobe = 4'h0;
        converter_select_n = 1'b1;
        converter_serial_clock = 1'b0;
        converter_serial_data = 1'b0;
    end
    // half of a 400 ns link period
    task automatic half_bit();
        repeat (4) @(negedge clock);
    endtask
    // clock idles low between words; released data shows the inverse, not a stale level
    task automatic shift_word(input logic [7:0] word);
        for (int i = 7; i >= 0; i--) begin
            atten_shift_data = word[i];
            half_bit();
            atten_shift_clock = 1'b1;
            half_bit();
            atten_shift_clock = 1'b0;
        end
        atten_shift_data = ~word[0];
    endtask
    task automatic latch(input int idx);
        latch_strobe[idx] = 1'b1;
        repeat (2) half_bit();
        latch_strobe[idx] = 1'b0;
        repeat (2) half_bit();
    endtask
    task automatic conv_frame(input logic [3:0] cmd, input logic [2:0] addr,
                              input logic [11:0] code);
        logic [23:0] frame;
        frame = {cmd, addr, 5'h00, code};
        converter_select_n = 1'b0;
        half_bit();
        for (int i = 23; i >= 0; i--) begin
            converter_serial_data = frame[i];
            half_bit();
            converter_serial_clock = 1'b1;
            half_bit();
            converter_serial_clock = 1'b0;
        end
        converter_select_n = 1'b1;
        converter_serial_data = ~frame[0];
        repeat (2) half_bit();
    endtask
endmodule // ffc_ctrl_model
`default_nettype wire

/* File: verif/feedback_frontend_control_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module feedback_frontend_control_port_test;
    logic        clock;
    logic        rst_n;
    logic        sclk, sdata, sel_n, cclk, cdata, t_line, t_out, t_oe_n, f_out, f_oe_n;
    logic [3:0]  strobe;
    wire  [3:0]  rb;
    logic [7:0]  set_long, set_vert, set_hor, set_back;
    logic [11:0] fan, drive, back, hor, vert, lng;
    int          n_fail = 0;
    int          comparisons = 0;
    assign t_line = t_oe_n ? 1'b1 : t_out;
    initial clock = 1'b0;
    always #25 clock = ~clock;
    ffc_ctrl_model ffc_ctrl_model_inst (.clock(clock), .atten_shift_clock(sclk),
        .atten_shift_data(sdata), .latch_strobe(strobe), .converter_select_n(sel_n),
        .converter_serial_clock(cclk), .converter_serial_data(cdata));
    ffc_control_port #(.TACH_HALF_CYCLES(10)) ffc_control_port_inst (.clock(clock),
        .rst_n(rst_n), .atten_shift_clock(sclk), .atten_shift_data(sdata),
        .longitudinal_latch_strobe(strobe[ffc_pkg::ATT_LONG]),
        .vertical_latch_strobe(strobe[ffc_pkg::ATT_VERT]),
        .horizontal_latch_strobe(strobe[ffc_pkg::ATT_HOR]),
        .backend_latch_strobe(strobe[ffc_pkg::ATT_BACK]),
        .longitudinal_shift_readback(rb[ffc_pkg::ATT_LONG]),
        .vertical_shift_readback(rb[ffc_pkg::ATT_VERT]),
        .horizontal_shift_readback(rb[ffc_pkg::ATT_HOR]),
        .backend_shift_readback(rb[ffc_pkg::ATT_BACK]),
        .longitudinal_setting(set_long),
        .vertical_setting(set_vert),
        .horizontal_setting(set_hor),
        .backend_setting(set_back), .converter_select_n(sel_n),
        .converter_serial_clock(cclk), .converter_serial_data(cdata),
        .fan_speed_channel(fan), .fan_drive_level(drive), .backend_phase_channel(back),
        .horizontal_phase_channel(hor), .vertical_phase_channel(vert),
        .longitudinal_phase_channel(lng), .thermometer_line_in(t_line),
        .thermometer_line_out(t_out), .thermometer_line_oe_n(t_oe_n),
        .fan_speed_pulse_out(f_out), .fan_speed_pulse_oe_n(f_oe_n));
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic test_reset();
        check("fan code", 12'h000, fan);
        check("long code", 12'h000, lng);
        check("fan drive", 12'hfff, drive);
        check("thermometer released", 12'h001, {11'h000, t_oe_n});
        $display("test_reset finished");
    endtask
    task automatic test_atten();
        ffc_ctrl_model_inst.shift_word(8'ha5);
        repeat (6) @(negedge clock);
        check("readbacks a5", 12'h00f, {8'h00, rb});
        ffc_ctrl_model_inst.latch(ffc_pkg::ATT_VERT);
        check("vert setting", 12'h0a5, {4'h0, set_vert});
        check("long setting", 12'h000, {4'h0, set_long});
        ffc_ctrl_model_inst.shift_word(8'h3c);
        repeat (6) @(negedge clock);
        check("readbacks 3c", 12'h000, {8'h00, rb});
        ffc_ctrl_model_inst.latch(ffc_pkg::ATT_BACK);
        check("back setting", 12'h03c, {4'h0, set_back});
        check("vert kept", 12'h0a5, {4'h0, set_vert});
        check("hor untouched", 12'h000, {4'h0, set_hor});
        $display("test_atten finished");
    endtask
    task automatic test_converter();
        logic [3:0] ld;
        ld = ffc_pkg::CONV_CMD_LOAD_UPDATE;
        ffc_ctrl_model_inst.conv_frame(ld, 3'd0, 12'h123);
        check("fan code", 12'h123, fan);
        check("fan drive", 12'hedc, drive);
        ffc_ctrl_model_inst.conv_frame(ld, 3'd4, 12'h0ab);
        check("back code", 12'h0ab, back);
        ffc_ctrl_model_inst.conv_frame(ld, 3'd5, 12'hfff);
        check("hor code", 12'hfff, hor);
        ffc_ctrl_model_inst.conv_frame(ld, 3'd6, 12'h800);
        check("vert code", 12'h800, vert);
        ffc_ctrl_model_inst.conv_frame(ld, 3'd7, 12'h001);
        check("long code", 12'h001, lng);
        ffc_ctrl_model_inst.conv_frame(ld, 3'd1, 12'h555);
        check("unused leaves back", 12'h0ab, back);
        check("unused leaves fan", 12'h123, fan);
        ffc_ctrl_model_inst.conv_frame(4'h2, 3'd4, 12'h777);
        check("bad command", 12'h0ab, back);
        $display("test_converter finished");
    endtask
    // reset in mid-run: codes go back to zero, then a fresh frame still lands
    task automatic test_midrun_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        check("fan code in reset", 12'h000, fan);
        check("back code in reset", 12'h000, back);
        check("fan drive in reset", 12'hfff, drive);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        ffc_ctrl_model_inst.conv_frame(ffc_pkg::CONV_CMD_LOAD_UPDATE, 3'd4, 12'h0cd);
        check("back after reset", 12'h0cd, back);
        check("fan kept after reset", 12'h000, fan);
        $display("test_midrun_reset finished");
    endtask
    task automatic test_tach();
        int     toggles;
        int     bad;
        logic   last;
        longint hz;
        longint rpm;
        toggles = 0;
        bad = 0;
        last = f_oe_n;
        repeat (200) begin
            @(negedge clock);
            if (f_oe_n !== last) toggles++;
            if (f_oe_n === 1'b0 && f_out !== 1'b0) bad++;
            last = f_oe_n;
        end
        // two edges per period over a 10000 ns window
        hz = longint'(toggles / 2) * 1000000000 / 10000;
        rpm = hz * 30;
        check("tach toggles", 12'd20, toggles[11:0]);
        check("tach revolutions", 12'd5, 12'(toggles / ffc_pkg::TACH_EDGES_PER_REV));
        check("tach pull low", 12'd0, bad[11:0]);
        // one turn is four half periods of 10 cycles at 50 ns: 2 us, so 30000000 rpm
        check("tach rpm over 10000", 12'd3000, 12'(rpm / 10000));
        $display("test_tach finished");
    endtask
    // generous span: whole sequence needs well under 200 us
    initial begin
        #2000000;
        n_fail++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        test_reset();
        test_atten();
        test_converter();
        test_midrun_reset();
        test_tach();
        close_out();
    end
endmodule // feedback_frontend_control_port_test
`default_nettype wire
